// File: hdl/sdsc_dma.sv
// serial dma status flags, byte offsets, control and receive fifo
// What this block does
// - overrun on buffer A sets status bit 4
// - full fifo overrun flags next loaded buffer
// - A overrun clears on A load or reset
// - transmit active flags at bits 2 and 3
// - receive active flags at bits 0 and 1
// - read-only 13-bit next-byte offset, rx A
// - read-only 13-bit next-byte offset, rx B
// - read-only 13-bit offset of active tx buffer
// - offsets wrap to zero when buffer unloads
// - load bit starts buffer, self-clears on completion
// - dma reset bits reset direction, self-clear
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module sdsc_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end
  logic [W-1:0] mem [D];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  assign in_ready = !(wp_r[AW] != rp_r[AW] && wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (flush) begin
      wp_nxt = '0;
      rp_nxt = '0;
    end else begin
      if (push) wp_nxt = (AW+1)'(wp_r + 1'b1);
      if (pop) rp_nxt = (AW+1)'(rp_r + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // storage needs no reset; only pointers define contents
  always_ff @(posedge clk) begin
    if (push) mem[wp_r[AW-1:0]] <= in_data;
  end
endmodule

module sdsc_dma #(
  parameter int DEPTH = sdsc_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sdsc_pkg::sdsc_bufmap_s buf_map,
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire sdsc_pkg::sdsc_byte_s rx_in_byte,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [12:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  output logic mem_rd_en,
  output logic [12:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  output logic [7:0] tx_out_data
);
  import sdsc_pkg::*;

  logic [3:0] load_r, load_nxt, set_load, done;
  logic [CNT_W-1:0] cnt_a_r, cnt_a_nxt, cnt_b_r, cnt_b_nxt, tx_cnt_r, tx_cnt_nxt;
  logic [1:0] ovr_r, ovr_nxt, frm_r, frm_nxt, par_r, par_nxt;
  logic pend_r, pend_nxt, rx_buf_r, rx_buf_nxt, tx_buf_r, tx_buf_nxt;
  sdsc_bufmap_s map_r, map_nxt;
  sdsc_txst_e tx_st_r, tx_st_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [15:0] status;
  logic wr_ctrl, rx_rst, tx_rst, hit, wr_fire, rx_full, tx_last;
  logic rx_act, fifo_valid;
  sdsc_byte_s fifo_byte;
  sdsc_span_s rx_span, tx_span;
  logic [CNT_W-1:0] rx_cnt;

  if (DEPTH < 2) begin : g_bad_depth
    $error("receive fifo depth too small");
  end

  // the serial engine sees back-pressure through rx_in_ready
  sdsc_fifo #(.W($bits(sdsc_byte_s)), .D(DEPTH)) u_rx_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .flush(rx_rst),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data(rx_in_byte),
    .out_valid(fifo_valid),
    .out_ready(rx_act && mem_wr_ready),
    .out_data(fifo_byte)
  );

  // apb decode; zero wait states
  assign pready = 1'b1;
  assign hit = paddr == ADR_RXCNT_A || paddr == ADR_RXCNT_B || paddr == ADR_TXCNT ||
               paddr == ADR_STAT || paddr == ADR_CTRL;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_r;
  assign wr_ctrl = psel && penable && pwrite && paddr == ADR_CTRL;
  assign set_load = wr_ctrl ? pwdata[3:0] : 4'h0;
  assign rx_rst = wr_ctrl && pwdata[CTRL_RXRST];
  assign tx_rst = wr_ctrl && pwdata[CTRL_TXRST];

  // receive side
  assign rx_span = rx_buf_r ? map_r.rxb : map_r.rxa;
  assign rx_cnt = rx_buf_r ? cnt_b_r : cnt_a_r;
  assign rx_act = load_r[{1'b0, rx_buf_r}];
  assign mem_wr_valid = rx_act && fifo_valid;
  assign mem_wr_addr = CNT_W'(rx_span.beg + rx_cnt);
  assign mem_wr_data = fifo_byte.data;
  assign wr_fire = mem_wr_valid && mem_wr_ready;
  assign rx_full = mem_wr_addr == rx_span.fin;

  // transmit side
  assign tx_span = tx_buf_r ? map_r.txb : map_r.txa;
  assign mem_rd_en = tx_st_r == TX_READ;
  assign mem_rd_addr = CNT_W'(tx_span.beg + tx_cnt_r);
  assign tx_last = mem_rd_addr == tx_span.fin;
  assign tx_out_valid = tx_st_r == TX_SEND;
  assign tx_out_data = tx_data_r;

  always_comb begin
    status = 16'h0000;
    status[ST_RXACT_A] = load_r[LD_RXA] && !rx_buf_r;
    status[ST_RXACT_B] = load_r[LD_RXB] && rx_buf_r;
    status[ST_TXACT_A] = tx_st_r != TX_IDLE && !tx_buf_r;
    status[ST_TXACT_B] = tx_st_r != TX_IDLE && tx_buf_r;
    status[ST_OVR_A] = ovr_r[0];
    status[ST_OVR_B] = ovr_r[1];
    status[ST_PAR_A] = par_r[0];
    status[ST_PAR_B] = par_r[1];
    status[ST_FRM_A] = frm_r[0];
    status[ST_FRM_B] = frm_r[1];
  end

  always_comb begin
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      case (paddr)
        ADR_RXCNT_A: prdata_nxt = {19'h00000, cnt_a_r};
        ADR_RXCNT_B: prdata_nxt = {19'h00000, cnt_b_r};
        ADR_TXCNT: prdata_nxt = {19'h00000, tx_cnt_r};
        ADR_STAT: prdata_nxt = {16'h0000, status};
        ADR_CTRL: prdata_nxt = {28'h0000000, load_r}; // reset bits read zero
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    done = 4'h0;
    cnt_a_nxt = cnt_a_r;
    cnt_b_nxt = cnt_b_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_st_nxt = tx_st_r;
    tx_data_nxt = tx_data_r;
    tx_buf_nxt = tx_buf_r;
    rx_buf_nxt = rx_buf_r;
    ovr_nxt = ovr_r;
    frm_nxt = frm_r;
    par_nxt = par_r;
    pend_nxt = pend_r;
    map_nxt = map_r;
    // a loaded buffer latches its span and drops its old error flags
    if (set_load[LD_RXA]) map_nxt.rxa = buf_map.rxa;
    if (set_load[LD_RXB]) map_nxt.rxb = buf_map.rxb;
    if (set_load[LD_TXA]) map_nxt.txa = buf_map.txa;
    if (set_load[LD_TXB]) map_nxt.txb = buf_map.txb;
    if (set_load[LD_RXA]) begin
      ovr_nxt[0] = 1'b0;
      frm_nxt[0] = 1'b0;
      par_nxt[0] = 1'b0;
    end
    if (set_load[LD_RXB]) begin
      ovr_nxt[1] = 1'b0;
      frm_nxt[1] = 1'b0;
      par_nxt[1] = 1'b0;
    end
    if (rx_rst) begin
      ovr_nxt = 2'b00;
      frm_nxt = 2'b00;
      par_nxt = 2'b00;
      pend_nxt = 1'b0;
      cnt_a_nxt = CNT_RESET;
      cnt_b_nxt = CNT_RESET;
      rx_buf_nxt = 1'b0;
    end
    // a held overrun goes to whichever buffer loads next, A first on a tie
    if (pend_r && set_load[LD_RXA]) begin
      ovr_nxt[0] = 1'b1;
      pend_nxt = 1'b0;
    end else if (pend_r && set_load[LD_RXB]) begin
      ovr_nxt[1] = 1'b1;
      pend_nxt = 1'b0;
    end
    if (rx_in_valid && !rx_in_ready) pend_nxt = 1'b1;
    // rx buffer pointer moves only once the current buffer has unloaded
    if (!rx_act && load_r[{1'b0, !rx_buf_r}] && !rx_rst) rx_buf_nxt = !rx_buf_r;
    if (wr_fire) begin
      if (fifo_byte.frame) frm_nxt[rx_buf_r] = 1'b1;
      if (fifo_byte.parity) par_nxt[rx_buf_r] = 1'b1;
      done[{1'b0, rx_buf_r}] = rx_full;
      if (rx_buf_r) begin
        cnt_b_nxt = (rx_full || rx_rst) ? CNT_RESET : CNT_W'(cnt_b_r + 1'b1);
      end else begin
        cnt_a_nxt = (rx_full || rx_rst) ? CNT_RESET : CNT_W'(cnt_a_r + 1'b1);
      end
    end
    case (tx_st_r)
      TX_IDLE: begin
        if (load_r[{1'b1, tx_buf_r}]) begin
          tx_st_nxt = TX_READ;
        end else if (load_r[{1'b1, !tx_buf_r}]) begin
          tx_buf_nxt = !tx_buf_r;
          tx_st_nxt = TX_READ;
        end
      end
      TX_READ: tx_st_nxt = TX_WAIT;
      TX_WAIT: begin
        tx_data_nxt = mem_rd_data;
        tx_st_nxt = TX_SEND;
      end
      TX_SEND: begin
        if (tx_out_ready) begin
          tx_cnt_nxt = tx_last ? CNT_RESET : CNT_W'(tx_cnt_r + 1'b1);
          tx_st_nxt = tx_last ? TX_IDLE : TX_READ;
          done[{1'b1, tx_buf_r}] = tx_last;
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
    if (tx_rst) begin
      tx_st_nxt = TX_IDLE;
      tx_cnt_nxt = CNT_RESET;
      tx_buf_nxt = 1'b0;
    end
    // a new load wins over a completion in the same cycle; a reset wins over both
    load_nxt = (load_r & ~done) | set_load;
    if (rx_rst) load_nxt[LD_RXB:LD_RXA] = 2'b00;
    if (tx_rst) load_nxt[LD_TXB:LD_TXA] = 2'b00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_r <= LOAD_RESET;
      cnt_a_r <= CNT_RESET;
      cnt_b_r <= CNT_RESET;
      tx_cnt_r <= CNT_RESET;
      ovr_r <= 2'b00;
      frm_r <= 2'b00;
      par_r <= 2'b00;
      pend_r <= 1'b0;
      rx_buf_r <= 1'b0;
      tx_buf_r <= 1'b0;
      map_r <= '0;
      tx_st_r <= TX_IDLE;
      tx_data_r <= 8'h00;
      prdata_r <= 32'h00000000;
    end else begin
      load_r <= load_nxt;
      cnt_a_r <= cnt_a_nxt;
      cnt_b_r <= cnt_b_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      ovr_r <= ovr_nxt;
      frm_r <= frm_nxt;
      par_r <= par_nxt;
      pend_r <= pend_nxt;
      rx_buf_r <= rx_buf_nxt;
      tx_buf_r <= tx_buf_nxt;
      map_r <= map_nxt;
      tx_st_r <= tx_st_nxt;
      tx_data_r <= tx_data_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ovr_held: assert property (rx_in_valid && !rx_in_ready |=> pend_r)
    else $error("refused byte did not raise pending overrun");
  chk_ovr_a_set: assert property (pend_r && set_load[LD_RXA] |=> status[ST_OVR_A])
    else $error("overrun not flagged on buffer A");
  // a byte refused in the hand-off cycle raises pending again
  chk_ovr_b_set: assert property (
    pend_r && set_load[LD_RXB] && !set_load[LD_RXA] && !(rx_in_valid && !rx_in_ready)
    |=> status[ST_OVR_B] && !pend_r)
    else $error("overrun not flagged on buffer B");
  chk_flags_reset: assert property (
    rx_rst && !pend_r && !wr_fire |=> status[9:4] == 6'h00 && load_r[1:0] == 2'b00)
    else $error("receive reset left flags or loads set");
  chk_tx_active: assert property (tx_out_valid |-> status[ST_TXACT_A] != status[ST_TXACT_B])
    else $error("transmit active flag wrong while sending");
  chk_rx_active: assert property (wr_fire |-> status[ST_RXACT_A] || status[ST_RXACT_B])
    else $error("receive write without active flag");
  chk_rx_step: assert property (
    wr_fire && !rx_full && !rx_buf_r && !rx_rst |=> cnt_a_r == CNT_W'($past(cnt_a_r) + 1'b1))
    else $error("receive offset A did not advance by one");
  chk_wrap_zero: assert property (
    wr_fire && rx_full && !rx_rst && !set_load[{1'b0, rx_buf_r}]
    |=> rx_cnt == CNT_RESET && !load_r[{1'b0, $past(rx_buf_r)}])
    else $error("full receive buffer did not unload and wrap");
  chk_tx_step: assert property (
    tx_out_valid && tx_out_ready && !tx_rst |=> tx_cnt_r == (
      $past(tx_last) ? CNT_RESET : CNT_W'($past(tx_cnt_r) + 1'b1)))
    else $error("transmit offset wrong after a byte");
  chk_load_set: assert property (set_load[LD_RXA] && !rx_rst |=> load_r[LD_RXA] [*1])
    else $error("load bit did not set");
endmodule

`default_nettype wire

// File: common/sdsc_pkg.sv
// shared constants and types of the serial dma status and byte-count block
package sdsc_pkg;
  localparam int CNT_W = 13;
  localparam int FIFO_DEPTH = 16;
  // register indices; the byte address on the bus is four times the index
  localparam logic [15:0] IDX_RXCNT_A = 16'h4490;
  localparam logic [15:0] IDX_RXCNT_B = 16'h4492;
  localparam logic [15:0] IDX_TXCNT = 16'h4494;
  localparam logic [15:0] IDX_STAT = 16'h4496;
  localparam logic [15:0] IDX_CTRL = 16'h4498;
  localparam logic [31:0] ADR_RXCNT_A = {14'h0000, IDX_RXCNT_A, 2'b00};
  localparam logic [31:0] ADR_RXCNT_B = {14'h0000, IDX_RXCNT_B, 2'b00};
  localparam logic [31:0] ADR_TXCNT = {14'h0000, IDX_TXCNT, 2'b00};
  localparam logic [31:0] ADR_STAT = {14'h0000, IDX_STAT, 2'b00};
  localparam logic [31:0] ADR_CTRL = {14'h0000, IDX_CTRL, 2'b00};
  // control register bits
  localparam int LD_RXA = 0;
  localparam int LD_RXB = 1;
  localparam int LD_TXA = 2;
  localparam int LD_TXB = 3;
  localparam int CTRL_RXRST = 4;
  localparam int CTRL_TXRST = 5;
  // status register bits
  localparam int ST_RXACT_A = 0;
  localparam int ST_RXACT_B = 1;
  localparam int ST_TXACT_A = 2;
  localparam int ST_TXACT_B = 3;
  localparam int ST_OVR_A = 4;
  localparam int ST_OVR_B = 5;
  localparam int ST_PAR_A = 6;
  localparam int ST_PAR_B = 7;
  localparam int ST_FRM_A = 8;
  localparam int ST_FRM_B = 9;
  localparam logic [CNT_W-1:0] CNT_RESET = 13'h0000;
  localparam logic [3:0] LOAD_RESET = 4'h0;

  typedef struct packed {
    logic frame;
    logic parity;
    logic [7:0] data;
  } sdsc_byte_s;

  typedef struct packed {
    logic [CNT_W-1:0] beg;
    logic [CNT_W-1:0] fin;
  } sdsc_span_s;

  typedef struct packed {
    sdsc_span_s txb;
    sdsc_span_s txa;
    sdsc_span_s rxb;
    sdsc_span_s rxa;
  } sdsc_bufmap_s;

  typedef enum logic [1:0] {TX_IDLE, TX_READ, TX_WAIT, TX_SEND} sdsc_txst_e;
endpackage

// File: tb/sdsc_mem_model.sv
// buffer memory and transmit sink standing at the far side of the dma block
`timescale 1ns/1ns
`default_nettype none
module sdsc_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic tx_hold,
  input wire logic mem_wr_valid,
  output logic mem_wr_ready,
  input wire logic [12:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  input wire logic mem_rd_en,
  input wire logic [12:0] mem_rd_addr,
  output logic [7:0] mem_rd_data,
  input wire logic tx_out_valid,
  output logic tx_out_ready,
  input wire logic [7:0] tx_out_data
);
  logic [7:0] mem [0:8191];
  logic [7:0] last;
  logic [7:0] tx_q [$];
  logic rd_q;
  logic ph;
  // stalls alternate between the two sides so both see back-pressure
  assign mem_wr_ready = !(stall && ph);
  // tx_hold parks the sink so the bench can stop a buffer mid-way
  assign tx_out_ready = !(stall && !ph) && !tx_hold;
  // read data holds only in the cycle after the strobe, garbage otherwise
  assign mem_rd_data = rd_q ? last : ~last;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 1'b0;
      rd_q <= 1'b0;
      last <= 8'h00;
    end else begin
      ph <= ~ph;
      rd_q <= mem_rd_en;
      if (mem_rd_en) last <= mem[mem_rd_addr];
      if (mem_wr_valid && mem_wr_ready) mem[mem_wr_addr] <= mem_wr_data;
      if (tx_out_valid && tx_out_ready) tx_q.push_back(tx_out_data);
    end
  end
endmodule
`default_nettype wire

// File: tb/test_serial_dma_status_counters.sv
// self-checking bench for the serial dma status and byte-count block
`timescale 1ns/1ns
`default_nettype none
module test_serial_dma_status_counters;
  import sdsc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, errv, tx_hold;
  logic [31:0] paddr, pwdata, prdata, rdv;
  sdsc_bufmap_s buf_map;
  sdsc_byte_s rx_in_byte;
  logic rx_in_valid, rx_in_ready, mem_wr_valid, mem_wr_ready, mem_rd_en;
  logic tx_out_valid, tx_out_ready;
  logic [12:0] mem_wr_addr, mem_rd_addr;
  logic [7:0] mem_wr_data, mem_rd_data, tx_out_data;
  int err_count = 0;
  int checks = 0;
  sdsc_dma uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .buf_map, .rx_in_valid, .rx_in_ready, .rx_in_byte,
    .mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data, .mem_rd_en,
    .mem_rd_addr, .mem_rd_data, .tx_out_valid, .tx_out_ready, .tx_out_data);
  sdsc_mem_model mdl (.pclk, .presetn, .stall, .tx_hold, .mem_wr_valid, .mem_wr_ready,
    .mem_wr_addr, .mem_wr_data, .mem_rd_en, .mem_rd_addr, .mem_rd_data,
    .tx_out_valid, .tx_out_ready, .tx_out_data);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in this time step
    @(posedge pclk);
  endtask
  // polls a register until it shows the value, then compares once
  task poll(input logic [31:0] a, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rdv !== e && n < 200);
    chk($sformatf("reg %h", a), e, rdv);
  endtask
  // raw offers one byte for one cycle whether or not it is taken
  task send(input logic [7:0] d, input logic p, input logic raw);
    logic r;
    rx_in_valid <= 1'b1;
    rx_in_byte <= '{frame: 1'b0, parity: p, data: d};
    do begin
      @(negedge pclk);
      r = rx_in_ready;
      @(posedge pclk);
    end while (!r && !raw);
    rx_in_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task t_reset;
    poll(ADR_RXCNT_A, 32'h0);
    poll(ADR_RXCNT_B, 32'h0);
    poll(ADR_TXCNT, 32'h0);
    poll(ADR_STAT, 32'h0);
    chk("pslverr", 32'h0, {31'h0, errv});
    apb(1'b1, ADR_RXCNT_A, 32'h1fff);
    poll(ADR_RXCNT_A, 32'h0);
    apb(1'b0, ADR_STAT + 32'h4, 32'h0);
    chk("pslverr", 32'h1, {31'h0, errv});
    chk("unmapped", 32'h0, rdv);
    $display("test reset done");
  endtask
  task t_rxa;
    stall <= 1'b1;
    apb(1'b1, ADR_CTRL, 32'h1);
    poll(ADR_STAT, 32'h1);
    poll(ADR_CTRL, 32'h1);
    send(8'ha0, 1'b0, 1'b0);
    send(8'ha1, 1'b1, 1'b0);
    poll(ADR_RXCNT_A, 32'h2);
    send(8'ha2, 1'b0, 1'b0);
    send(8'ha3, 1'b0, 1'b0);
    poll(ADR_STAT, 32'h40);
    poll(ADR_CTRL, 32'h0);
    poll(ADR_RXCNT_A, 32'h0);
    for (int i = 0; i < 4; i++) chk("mem", 32'ha0 + i, {24'h0, mdl.mem[16 + i]});
    $display("test rx a done");
  endtask
  task t_ovr;
    stall <= 1'b0;
    for (int i = 0; i < 17; i++) send(i[7:0], 1'b0, i == 16);
    apb(1'b1, ADR_CTRL, 32'h1);
    poll(ADR_STAT, 32'h10);
    apb(1'b1, ADR_CTRL, 32'h1);
    poll(ADR_STAT, 32'h0);
    for (int i = 0; i < 9; i++) send(i[7:0], 1'b0, i == 8);
    apb(1'b1, ADR_CTRL, 32'h2);
    apb(1'b0, ADR_STAT, 32'h0);
    chk("overrun b", 32'h20, rdv & 32'h20);
    apb(1'b1, ADR_CTRL, 32'h10);
    poll(ADR_STAT, 32'h0);
    poll(ADR_CTRL, 32'h0);
    poll(ADR_RXCNT_B, 32'h0);
    chk("rx ready", 32'h1, {31'h0, rx_in_ready});
    $display("test overrun done");
  endtask
  task t_tx;
    stall <= 1'b1;
    apb(1'b1, ADR_CTRL, 32'h4);
    poll(ADR_STAT, 32'h4);
    poll(ADR_STAT, 32'h0);
    poll(ADR_TXCNT, 32'h0);
    // the overrun test refilled rx A, which shares the span, with bytes 4..7
    for (int i = 0; i < 4; i++) chk("tx byte", 32'h04 + i, {24'h0, mdl.tx_q[i]});
    tx_hold <= 1'b1;
    apb(1'b1, ADR_CTRL, 32'h8);
    poll(ADR_STAT, 32'h8);
    // let exactly one byte through so the offset is caught mid-buffer
    tx_hold <= 1'b0;
    do @(posedge pclk); while (!(tx_out_valid && tx_out_ready));
    tx_hold <= 1'b1;
    poll(ADR_TXCNT, 32'h1);
    chk("tx b byte", 32'h04, {24'h0, mdl.tx_q[4]});
    apb(1'b1, ADR_CTRL, 32'h20);
    poll(ADR_STAT, 32'h0);
    poll(ADR_TXCNT, 32'h0);
    $display("test tx done");
  endtask
  task stop_test;
    $display("%0d checks, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #200000;
    err_count++;
    stop_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, stall, rx_in_valid, tx_hold} = 7'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    rx_in_byte = 10'h000;
    buf_map = {13'h0010, 13'h0011, 13'h0010, 13'h0013,
      13'h0100, 13'h010f, 13'h0010, 13'h0013};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_rxa;
    t_ovr;
    t_tx;
    stop_test;
  end
endmodule
`default_nettype wire
